/* File: bic_contact_filter.sv */
// minimum-retention filter for one field contact
`timescale 1ns/1ps
module bic_contact_filter #(
  parameter int RETAIN_CYC = 2000000
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic raw_i, // contact, high = closed
  output logic level_o // accepted contact state
);
  localparam int W = $clog2(RETAIN_CYC + 1);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic level_ff;
  logic nxt_level;

  // a new state is taken only after it stood unbroken for RETAIN_CYC cycles
  always_comb begin
    nxt_level = level_ff;
    nxt_cnt = '0;
    if (raw_i != level_ff) begin
      if (cnt_ff >= W'(RETAIN_CYC - 1)) begin
        nxt_level = raw_i;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule : bic_contact_filter

/* File: bic_field.sv */
// field contacts and flame sensor facing the sequencer
`timescale 1ns/1ps
module bic_field #(
  parameter int HOLD_CYC = 8,
  parameter int OFF_CYC = 300,
  parameter int PS_IDX = 0
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic [3:0] want_i, // contact states asked for
  input wire logic [3:0] glitch_i, // short flips, on command only
  input wire logic flame_i, // flame asked for
  output logic [3:0] contact_o, // contacts, high = closed
  output logic flame_o // flame sensor
);
  logic [3:0] st_ff, nxt_st;
  int hold_ff, nxt_hold, off_ff, nxt_off;
  logic blk;
  // a reasserted pilot start waits out its minimum off time
  assign blk = want_i[PS_IDX] && !st_ff[PS_IDX] && off_ff < OFF_CYC;
  assign contact_o = st_ff ^ glitch_i;
  always_comb begin
    nxt_st = st_ff;
    nxt_hold = hold_ff + 1;
    nxt_off = st_ff[PS_IDX] ? 0 : off_ff + 1;
    if (want_i != st_ff && hold_ff >= HOLD_CYC && !blk) begin
      nxt_st = want_i;
      nxt_hold = 0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      hold_ff <= HOLD_CYC;
      off_ff <= OFF_CYC;
      flame_o <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      hold_ff <= nxt_hold;
      off_ff <= nxt_off;
      flame_o <= flame_i;
    end
  end
endmodule : bic_field

/* File: bic_map.svh */
// register offsets, field positions and timing counts of the interlock sequencer
`ifndef BIC_MAP_SVH
`define BIC_MAP_SVH

`define BIC_ADDR_W 12
`define BIC_A_CTRL 12'h000
`define BIC_A_FUNC 12'h004
`define BIC_A_OFFDLY 12'h008
`define BIC_A_STATUS 12'h00C
`define BIC_A_IRQ_STAT 12'h010
`define BIC_A_IRQ_MASK 12'h014

`define BIC_CTRL_RUN 0
`define BIC_CTRL_LO_RESET 1
`define BIC_FLD_W 4
`define BIC_FN_W 3

`define BIC_IRQ_W 3
`define BIC_IRQ_LOCK 0
`define BIC_IRQ_PROC 1
`define BIC_IRQ_MAIN_OFF 2

`define BIC_ST_PROC_LSB 0
`define BIC_ST_LOCK 3
`define BIC_ST_XCHK 4
`define BIC_ST_FLAME 5
`define BIC_ST_IN_LSB 8
`define BIC_ST_CAUSE_LSB 16

`define BIC_CLK_NS 100
`define BIC_RETAIN_MS 200
`define BIC_RETAIN_CYC ((`BIC_RETAIN_MS * 1000000 + `BIC_CLK_NS - 1) / `BIC_CLK_NS)
`define BIC_TICK_MS 100
`define BIC_TICK_CYC ((`BIC_TICK_MS * 1000000) / `BIC_CLK_NS)
`define BIC_PO_TRIAL_MS 5000
`define BIC_PO_TRIAL_TK (`BIC_PO_TRIAL_MS / `BIC_TICK_MS)
`define BIC_PO_NORM_MS 3000
`define BIC_PO_NORM_TK (`BIC_PO_NORM_MS / `BIC_TICK_MS)
`define BIC_OFFDLY_UNIT_MS 1000
`define BIC_OFFDLY_TK (`BIC_OFFDLY_UNIT_MS / `BIC_TICK_MS)
`define BIC_PURGE_TK_DEF 300
`define BIC_PTRIAL_TK_DEF 50
`define BIC_MTRIAL_TK_DEF 50

`endif

/* File: bic_pkg.sv */
// types shared by the interlock sequencer modules
package bic_pkg;

  typedef enum logic [2:0] {
    BIC_P_STANDBY = 3'b000,
    BIC_P_PREPURGE = 3'b001,
    BIC_P_PILOT_TRIAL = 3'b010,
    BIC_P_PILOT_ONLY = 3'b011,
    BIC_P_MAIN_TRIAL = 3'b100,
    BIC_P_NORMAL = 3'b101,
    BIC_P_LOCKOUT = 3'b110
  } bic_proc_t;

  typedef enum logic [2:0] {
    BIC_FN_DISABLED = 3'b000,
    BIC_FN_MANUAL_VALVE = 3'b001,
    BIC_FN_MANUAL_LIMIT = 3'b010,
    BIC_FN_PILOT_START = 3'b011,
    BIC_FN_MAIN_START = 3'b100,
    BIC_FN_INTERLOCK = 3'b101
  } bic_fn_t;

  typedef struct packed {
    logic pilot;
    logic igniter;
    logic main;
  } bic_valves_t;

endpackage : bic_pkg

/* File: bic_seq_properties.sv */
// port-level assertions of the interlock sequencer
`timescale 1ns/1ps
`include "bic_map.svh"
module bic_seq_properties #(
  parameter int TICK_CYC = 10,
  parameter int PTRIAL_TK = 3
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [`BIC_ADDR_W-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic pilot_valve_o, // pilot valve
  input wire logic igniter_o, // igniter
  input wire logic main_valve_o, // main valve
  input wire logic lockout_o // lockout
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // first tick may come one cycle after entry, so one tick of slack
  localparam int PO_MIN = (`BIC_PO_NORM_TK - 1) * TICK_CYC;
  localparam int IG_MAX = (PTRIAL_TK + 1) * TICK_CYC;
  logic [31:0] po_ff, nxt_po, ig_ff, nxt_ig;
  logic hit, lo_clr;
  assign hit = paddr inside {`BIC_A_CTRL, `BIC_A_FUNC, `BIC_A_OFFDLY,
    `BIC_A_STATUS, `BIC_A_IRQ_STAT, `BIC_A_IRQ_MASK};
  assign lo_clr = psel && penable && pwrite && paddr == `BIC_A_CTRL
    && pwdata[`BIC_CTRL_LO_RESET];
  always_comb begin
    nxt_po = (pilot_valve_o && !igniter_o && !main_valve_o) ? po_ff + 1 : '0;
    nxt_ig = igniter_o ? ig_ff + 1 : '0;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      po_ff <= '0;
      ig_ff <= '0;
    end else begin
      po_ff <= nxt_po;
      ig_ff <= nxt_ig;
    end
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_lock2;
    lockout_o ##1 lockout_o;
  endsequence
  property p_lock_dry;
    s_lock2 |-> !pilot_valve_o && !igniter_o && !main_valve_o;
  endproperty
  a_lock_dry: assert property (p_lock_dry) else $error("valve on in lockout");
  property p_lock_hold;
    lockout_o && !lo_clr |=> lockout_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout left");
  property p_ign_pilot;
    igniter_o |-> pilot_valve_o && !main_valve_o;
  endproperty
  a_ign_pilot: assert property (p_ign_pilot) else $error("igniter alone");
  property p_main_pilot;
    main_valve_o |-> pilot_valve_o;
  endproperty
  a_main_pilot: assert property (p_main_pilot) else $error("main without pilot");
  property p_main_wait;
    $rose(main_valve_o) |-> po_ff >= PO_MIN;
  endproperty
  a_main_wait: assert property (p_main_wait) else $error("pilot only short");
  property p_ign_len;
    igniter_o |-> ig_ff <= IG_MAX;
  endproperty
  a_ign_len: assert property (p_ign_len) else $error("igniter too long");
  property p_ready;
    s_acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    s_acc |-> pslverr == !hit;
  endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_rd_zero;
    s_acc ##0 (!pwrite && !hit) |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
endmodule : bic_seq_properties

bind bic_sequencer bic_seq_properties #(.TICK_CYC(TICK_CYC), .PTRIAL_TK(PTRIAL_TK))
  bic_seq_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pilot_valve_o(pilot_valve_o),
  .igniter_o(igniter_o), .main_valve_o(main_valve_o), .lockout_o(lockout_o));

/* File: bic_sequencer.sv */
// burner input interlock and pilot/main start sequencer with apb registers
//
// Notes on behaviour
// - manual valve closed keeps the unit waiting in standby unless cross-check locks out
// - limit switch open or unset: valve off is normal, valve on locks out
// - limit switch closed: valve off locks out, valve on is normal
// - manual valve open or unset: limit open normal, limit closed locks out
// - manual valve closed: limit open locks out, limit closed is normal
// - a disabled input affects nothing but its own input bit in status
// - contact states count only after standing 0.2 s; field holds them that long
// - control type inputs steer transitions only, never lockout
// - interlock inputs lock out when open longer than their off delay
// - no prepurge until pilot start is asserted; with no input set to pilot start the code treats it as asserted
// - pilot only holds 5 s after pilot trial; main start off then blocks main trial
// - main start off in normal combustion closes main valve, back to pilot only
// - after normal combustion pilot only holds 3 s before main trial
`timescale 1ns/1ps
`include "bic_map.svh"
module bic_sequencer #(
  parameter int N_IN = 4,
  parameter int RETAIN_CYC = `BIC_RETAIN_CYC,
  parameter int TICK_CYC = `BIC_TICK_CYC,
  parameter int PURGE_TK = `BIC_PURGE_TK_DEF,
  parameter int PTRIAL_TK = `BIC_PTRIAL_TK_DEF,
  parameter int MTRIAL_TK = `BIC_MTRIAL_TK_DEF
) (
  input wire logic clk_i, // system clock, 10 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [`BIC_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [N_IN-1:0] contact_i, // field contacts, high = closed
  input wire logic flame_i, // flame detected
  output logic pilot_valve_o, // pilot valve drive
  output logic igniter_o, // igniter drive
  output logic main_valve_o, // main shutoff valve drive
  output logic lockout_o, // lockout latched
  output logic irq_o // interrupt, level
);
  localparam int TW = 16;

  logic tick;
  logic [N_IN-1:0] level;
  logic [N_IN-1:0] il_expired;
  logic [N_IN-1:0] fn_mv, fn_ml, fn_ps, fn_ms;

  // registers
  logic run_ff, nxt_run;
  logic [N_IN*`BIC_FLD_W-1:0] func_ff, nxt_func;
  logic [N_IN*`BIC_FLD_W-1:0] dly_ff, nxt_dly;
  logic [`BIC_IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [`BIC_IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic lo_reset;

  // sequencer state
  bic_pkg::bic_proc_t proc_ff, nxt_proc;
  logic [TW-1:0] tmr_ff, nxt_tmr;
  logic [TW-1:0] po_lim_ff, nxt_po_lim;
  logic [N_IN-1:0] cause_ff, nxt_cause;
  logic xchk_ff, nxt_xchk;
  logic flame_ff, nxt_flame;
  bic_pkg::bic_valves_t valves_ff, nxt_valves;

  bic_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      // eight bits so the longest settable delay (15 x 10 ticks) is not cut
      logic [7:0] off_ff;
      logic [7:0] nxt_off;
      logic [`BIC_FN_W-1:0] fn;
      logic [7:0] dly_tk;

      bic_contact_filter #(.RETAIN_CYC(RETAIN_CYC)) u_filt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .raw_i(contact_i[gi]),
        .level_o(level[gi])
      );

      assign fn = func_ff[gi*`BIC_FLD_W +: `BIC_FN_W];
      assign dly_tk = 8'(dly_ff[gi*`BIC_FLD_W +: `BIC_FLD_W] * `BIC_OFFDLY_TK);
      // disabled maps to no function bit at all
      assign fn_mv[gi] = (fn == bic_pkg::BIC_FN_MANUAL_VALVE) && level[gi];
      assign fn_ml[gi] = (fn == bic_pkg::BIC_FN_MANUAL_LIMIT) && level[gi];
      assign fn_ps[gi] = (fn == bic_pkg::BIC_FN_PILOT_START);
      assign fn_ms[gi] = (fn == bic_pkg::BIC_FN_MAIN_START);

      always_comb begin
        nxt_off = 8'h00;
        if (fn == bic_pkg::BIC_FN_INTERLOCK && !level[gi]) begin
          nxt_off = (tick && off_ff != 8'hFF) ? off_ff + 8'h01 : off_ff;
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          off_ff <= 8'h00;
        end else begin
          off_ff <= nxt_off;
        end
      end

      // open strictly longer than the set delay
      assign il_expired[gi] = (fn == bic_pkg::BIC_FN_INTERLOCK) && !level[gi]
                              && (off_ff > dly_tk);
    end
  endgenerate

  // start inputs that are not configured do not block the sequence
  logic pstart, mstart, mv_on, ml_on, xchk, lock_req;
  always_comb begin
    pstart = 1'b1;
    mstart = 1'b1;
    for (int i = 0; i < N_IN; i++) begin
      if (fn_ps[i]) begin
        pstart = pstart & level[i];
      end
      if (fn_ms[i]) begin
        mstart = mstart & level[i];
      end
    end
    mv_on = |fn_mv;
    ml_on = |fn_ml;
    // unset partner reads as open, so one xor covers all four pairings
    xchk = mv_on ^ ml_on;
    lock_req = xchk || (|il_expired);
  end

  // apb
  logic acc, wr, rd_setup;
  logic mapped;
  always_comb begin
    acc = psel && penable;
    wr = acc && pwrite;
    rd_setup = psel && !penable && !pwrite;
    mapped = (paddr == `BIC_A_CTRL) || (paddr == `BIC_A_FUNC) || (paddr == `BIC_A_OFFDLY)
             || (paddr == `BIC_A_STATUS) || (paddr == `BIC_A_IRQ_STAT)
             || (paddr == `BIC_A_IRQ_MASK);
  end
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[`BIC_ST_PROC_LSB +: 3] = proc_ff;
    status[`BIC_ST_LOCK] = (proc_ff == bic_pkg::BIC_P_LOCKOUT);
    status[`BIC_ST_XCHK] = xchk_ff;
    status[`BIC_ST_FLAME] = flame_ff;
    status[`BIC_ST_IN_LSB +: N_IN] = level;
    status[`BIC_ST_CAUSE_LSB +: N_IN] = cause_ff;
  end

  logic ev_lock, ev_proc, ev_main_off;
  always_comb begin
    nxt_run = run_ff;
    nxt_func = func_ff;
    nxt_dly = dly_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_prdata = prdata_ff;
    lo_reset = 1'b0;
    if (wr) begin
      if (paddr == `BIC_A_CTRL) begin
        nxt_run = pwdata[`BIC_CTRL_RUN];
        lo_reset = pwdata[`BIC_CTRL_LO_RESET];
      end else if (paddr == `BIC_A_FUNC) begin
        nxt_func = pwdata[N_IN*`BIC_FLD_W-1:0];
      end else if (paddr == `BIC_A_OFFDLY) begin
        nxt_dly = pwdata[N_IN*`BIC_FLD_W-1:0];
      end else if (paddr == `BIC_A_IRQ_STAT) begin
        nxt_irq_stat = irq_stat_ff & ~pwdata[`BIC_IRQ_W-1:0];
      end else if (paddr == `BIC_A_IRQ_MASK) begin
        nxt_irq_mask = pwdata[`BIC_IRQ_W-1:0];
      end
    end
    // events set after the clear so a same-cycle event survives
    if (ev_lock) begin
      nxt_irq_stat[`BIC_IRQ_LOCK] = 1'b1;
    end
    if (ev_proc) begin
      nxt_irq_stat[`BIC_IRQ_PROC] = 1'b1;
    end
    if (ev_main_off) begin
      nxt_irq_stat[`BIC_IRQ_MAIN_OFF] = 1'b1;
    end
    if (rd_setup) begin
      if (paddr == `BIC_A_CTRL) begin
        nxt_prdata = 32'(run_ff);
      end else if (paddr == `BIC_A_FUNC) begin
        nxt_prdata = 32'(func_ff);
      end else if (paddr == `BIC_A_OFFDLY) begin
        nxt_prdata = 32'(dly_ff);
      end else if (paddr == `BIC_A_STATUS) begin
        nxt_prdata = status;
      end else if (paddr == `BIC_A_IRQ_STAT) begin
        nxt_prdata = 32'(irq_stat_ff);
      end else if (paddr == `BIC_A_IRQ_MASK) begin
        nxt_prdata = 32'(irq_mask_ff);
      end else begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff <= 1'b0;
      func_ff <= '0;
      dly_ff <= '0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      run_ff <= nxt_run;
      func_ff <= nxt_func;
      dly_ff <= nxt_dly;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      prdata_ff <= nxt_prdata;
    end
  end

  // process sequencing
  always_comb begin
    nxt_proc = proc_ff;
    nxt_po_lim = po_lim_ff;
    nxt_cause = cause_ff;
    nxt_xchk = xchk_ff;
    nxt_flame = flame_ff;
    if (proc_ff == bic_pkg::BIC_P_LOCKOUT) begin
      // latched: only a software reset with causes gone leaves it
      if (lo_reset && !lock_req) begin
        nxt_proc = bic_pkg::BIC_P_STANDBY;
        nxt_cause = '0;
        nxt_xchk = 1'b0;
        nxt_flame = 1'b0;
      end
    end else if (lock_req) begin
      nxt_proc = bic_pkg::BIC_P_LOCKOUT;
      nxt_cause = il_expired;
      nxt_xchk = xchk;
    end else begin
      case (proc_ff)
        bic_pkg::BIC_P_STANDBY: begin
          if (run_ff && pstart && !mv_on) begin
            nxt_proc = bic_pkg::BIC_P_PREPURGE;
          end
        end
        bic_pkg::BIC_P_PREPURGE: begin
          if (!run_ff || !pstart || mv_on) begin
            nxt_proc = bic_pkg::BIC_P_STANDBY;
          end else if (tmr_ff >= TW'(PURGE_TK)) begin
            nxt_proc = bic_pkg::BIC_P_PILOT_TRIAL;
          end
        end
        bic_pkg::BIC_P_PILOT_TRIAL: begin
          if (tmr_ff >= TW'(PTRIAL_TK)) begin
            if (flame_i) begin
              nxt_proc = bic_pkg::BIC_P_PILOT_ONLY;
              nxt_po_lim = TW'(`BIC_PO_TRIAL_TK);
            end else begin
              nxt_proc = bic_pkg::BIC_P_LOCKOUT;
              nxt_flame = 1'b1;
            end
          end
        end
        bic_pkg::BIC_P_PILOT_ONLY: begin
          if (!flame_i) begin
            nxt_proc = bic_pkg::BIC_P_LOCKOUT;
            nxt_flame = 1'b1;
          end else if (!run_ff || !pstart) begin
            nxt_proc = bic_pkg::BIC_P_STANDBY;
          end else if (tmr_ff >= po_lim_ff && mstart) begin
            nxt_proc = bic_pkg::BIC_P_MAIN_TRIAL;
          end
        end
        bic_pkg::BIC_P_MAIN_TRIAL: begin
          // main start dropping here does not cut the trial short
          if (tmr_ff >= TW'(MTRIAL_TK)) begin
            if (flame_i) begin
              nxt_proc = bic_pkg::BIC_P_NORMAL;
            end else begin
              nxt_proc = bic_pkg::BIC_P_LOCKOUT;
              nxt_flame = 1'b1;
            end
          end
        end
        bic_pkg::BIC_P_NORMAL: begin
          if (!flame_i) begin
            nxt_proc = bic_pkg::BIC_P_LOCKOUT;
            nxt_flame = 1'b1;
          end else if (!run_ff || !pstart) begin
            nxt_proc = bic_pkg::BIC_P_STANDBY;
          end else if (!mstart) begin
            nxt_proc = bic_pkg::BIC_P_PILOT_ONLY;
            nxt_po_lim = TW'(`BIC_PO_NORM_TK);
          end
        end
        default: begin
          nxt_proc = bic_pkg::BIC_P_LOCKOUT;
        end
      endcase
    end
    nxt_tmr = (nxt_proc != proc_ff) ? '0
            : ((tick && tmr_ff != {TW{1'b1}}) ? tmr_ff + 1'b1 : tmr_ff);
    nxt_valves.pilot = (nxt_proc == bic_pkg::BIC_P_PILOT_TRIAL)
                       || (nxt_proc == bic_pkg::BIC_P_PILOT_ONLY)
                       || (nxt_proc == bic_pkg::BIC_P_MAIN_TRIAL)
                       || (nxt_proc == bic_pkg::BIC_P_NORMAL);
    nxt_valves.igniter = (nxt_proc == bic_pkg::BIC_P_PILOT_TRIAL);
    nxt_valves.main = (nxt_proc == bic_pkg::BIC_P_MAIN_TRIAL)
                      || (nxt_proc == bic_pkg::BIC_P_NORMAL);
    ev_proc = (nxt_proc != proc_ff);
    ev_lock = ev_proc && (nxt_proc == bic_pkg::BIC_P_LOCKOUT);
    ev_main_off = (proc_ff == bic_pkg::BIC_P_NORMAL)
                  && (nxt_proc == bic_pkg::BIC_P_PILOT_ONLY);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      proc_ff <= bic_pkg::BIC_P_STANDBY;
      tmr_ff <= '0;
      po_lim_ff <= '0;
      cause_ff <= '0;
      xchk_ff <= 1'b0;
      flame_ff <= 1'b0;
      valves_ff <= '0;
    end else begin
      proc_ff <= nxt_proc;
      tmr_ff <= nxt_tmr;
      po_lim_ff <= nxt_po_lim;
      cause_ff <= nxt_cause;
      xchk_ff <= nxt_xchk;
      flame_ff <= nxt_flame;
      valves_ff <= nxt_valves;
    end
  end

  assign prdata = prdata_ff;
  assign pilot_valve_o = valves_ff.pilot;
  assign igniter_o = valves_ff.igniter;
  assign main_valve_o = valves_ff.main;
  assign lockout_o = (proc_ff == bic_pkg::BIC_P_LOCKOUT);
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
endmodule : bic_sequencer

/* File: bic_tick_gen.sv */
// divider that makes the one-cycle timer tick
`timescale 1ns/1ps
module bic_tick_gen #(
  parameter int TICK_CYC = 1000000
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  output logic tick_o // one-cycle tick pulse
);
  localparam int W = $clog2(TICK_CYC);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == W'(TICK_CYC - 1));
    nxt_cnt = nxt_tick ? '0 : cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule : bic_tick_gen

/* File: tb.sv */
// self-checking bench of the interlock sequencer
`timescale 1ns/1ps
`include "bic_map.svh"
module tb;
  localparam int T = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fl_w = 1'b0;
  logic [`BIC_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic [3:0] want = '0;
  logic [3:0] glitch = '0;
  logic [3:0] contact;
  logic pready, pslverr, flame, lockout_o, irq_o, e;
  bic_pkg::bic_valves_t vlv;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  logic [15:0] lfsr = 16'h4759;
  int ra[$] = '{`BIC_A_CTRL, `BIC_A_FUNC, `BIC_A_OFFDLY, `BIC_A_IRQ_MASK};
  bic_sequencer #(.RETAIN_CYC(4), .TICK_CYC(T), .PURGE_TK(3), .PTRIAL_TK(5),
    .MTRIAL_TK(3)) bic_sequencer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .contact_i(contact),
    .flame_i(flame), .pilot_valve_o(vlv.pilot), .igniter_o(vlv.igniter),
    .main_valve_o(vlv.main), .lockout_o(lockout_o), .irq_o(irq_o));
  bic_field #(.HOLD_CYC(8), .OFF_CYC(30 * T)) bic_field_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .want_i(want), .glitch_i(glitch), .flame_i(fl_w),
    .contact_o(contact), .flame_o(flame));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  function automatic logic [15:0] rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : rnd
  function automatic bic_pkg::bic_valves_t vexp(input int p);
    return '{pilot: p inside {2, 3, 4, 5}, igniter: p == 2, main: p inside {4, 5}};
  endfunction : vexp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    repeat (20) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(q, x);
  endtask : rd
  task automatic st(input int p);
    apb(1'b0, `BIC_A_STATUS, '0);
    chk(q[2:0], p);
    chk(vlv, vexp(p));
    chk(lockout_o, p == 6);
  endtask : st
  task automatic upto(input int p, input int n);
    do begin
      apb(1'b0, `BIC_A_STATUS, '0);
      n--;
    end while (q[2:0] !== p[2:0] && n > 0);
    if (q[2:0] !== p[2:0]) begin
      num_errors++;
      give_verdict();
    end
  endtask : upto
  task automatic walk(input int a, input int b);
    for (int p = a; p <= b; p++) begin
      upto(p, 300);
      st(p);
    end
  endtask : walk
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (ra[i]) rd(ra[i][11:0], 32'h0000_0000);
    st(0);
    apb(1'b0, 12'h018, '0);
    chk(q, 32'h0000_0000);
    chk(e, 1'b1);
    // flame relay style setup: every input function left disabled
    apb(1'b1, `BIC_A_FUNC, 32'h0000_0000);
    rd(`BIC_A_FUNC, 32'h0000_0000);
    // codes above 3 include interlock, which could lock out on open contacts
    repeat (4) begin
      lfsr = rnd(lfsr);
      apb(1'b1, `BIC_A_FUNC, {16'h0000, lfsr & 16'h3333});
      rd(`BIC_A_FUNC, {16'h0000, lfsr & 16'h3333});
      apb(1'b1, `BIC_A_OFFDLY, {16'h0000, lfsr});
      rd(`BIC_A_OFFDLY, {16'h0000, lfsr});
    end
    apb(1'b1, `BIC_A_FUNC, 32'h0000_2143);
    apb(1'b1, `BIC_A_IRQ_MASK, 32'h0000_0007);
    apb(1'b1, `BIC_A_CTRL, 32'h0000_0001);
    glitch <= 4'h1;
    repeat (2 + lfsr[0]) @(posedge clk_i);
    glitch <= 4'h0;
    repeat (20) @(posedge clk_i);
    st(0);
    want <= 4'h1;
    walk(1, 2);
    fl_w <= 1'b1;
    walk(3, 3);
    repeat (600) @(posedge clk_i);
    st(3);
    want <= 4'h3;
    upto(4, 20);
    st(4);
    walk(5, 5);
    want <= 4'h1;
    upto(3, 20);
    st(3);
    t0 = cyc;
    chk(irq_o, 1'b1);
    rd(`BIC_A_IRQ_STAT, 32'h0000_0006);
    apb(1'b1, `BIC_A_IRQ_STAT, 32'h0000_0007);
    rd(`BIC_A_IRQ_STAT, 32'h0000_0000);
    chk(irq_o, 1'b0);
    want <= 4'h3;
    upto(4, 150);
    chk(cyc - t0 >= 280 && cyc - t0 <= 320, 1'b1);
    walk(5, 5);
    want <= 4'h7;
    upto(6, 20);
    st(6);
    chk(q[`BIC_ST_XCHK], 1'b1);
    chk(irq_o, 1'b1);
    fl_w <= 1'b0;
    apb(1'b1, `BIC_A_CTRL, 32'h0000_0003);
    st(6);
    want <= 4'hF;
    repeat (20) @(posedge clk_i);
    st(6);
    apb(1'b1, `BIC_A_CTRL, 32'h0000_0003);
    repeat (100) @(posedge clk_i);
    st(0);
    want <= 4'hB;
    upto(6, 20);
    st(6);
    apb(1'b1, `BIC_A_IRQ_MASK, 32'h0000_0000);
    chk(irq_o, 1'b0);
    rd(`BIC_A_IRQ_STAT, 32'h0000_0003);
    apb(1'b1, `BIC_A_IRQ_STAT, 32'h0000_0007);
    rd(`BIC_A_IRQ_STAT, 32'h0000_0000);
    apb(1'b1, `BIC_A_FUNC, 32'h0000_5043);
    apb(1'b1, `BIC_A_OFFDLY, 32'h0000_1000);
    want <= 4'hF;
    apb(1'b1, `BIC_A_CTRL, 32'h0000_0003);
    walk(1, 2);
    fl_w <= 1'b1;
    walk(3, 3);
    t0 = cyc;
    upto(4, 250);
    chk(cyc - t0 >= 480 && cyc - t0 <= 520, 1'b1);
    walk(5, 5);
    want <= 4'h7;
    repeat (90) @(posedge clk_i);
    chk(lockout_o, 1'b0);
    upto(6, 30);
    st(6);
    chk(q[`BIC_ST_CAUSE_LSB + 3], 1'b1);
    give_verdict();
  end
endmodule : tb
